// file: pkg/fdl_regs.svh
// Register map, field positions and reset values of the divider and level control block
`ifndef FDL_REGS_SVH
`define FDL_REGS_SVH
`define FDL_A_STAT 4'h0
`define FDL_A_PWR 4'h2
`define FDL_A_CTL 4'h3
`define FDL_A_SEED 4'h5
`define FDL_A_NDHI 4'h6
`define FDL_A_NDLO 4'h7
`define FDL_A_NUMH 4'h8
`define FDL_A_NUMM 4'h9
`define FDL_A_NUML 4'hA
`define FDL_A_ODIV 4'hB
`define FDL_A_ACAL_LO 4'h6
`define FDL_A_LAST 4'hA
`define FDL_RST_PWR 8'h06
`define FDL_RST_CTL 8'h3E
`define FDL_RST_SEED 8'h11
`define FDL_RST_NDHI 8'h08
`define FDL_RST_NDLO 8'hFA
`define FDL_RST_NUMH 8'h3F
`define FDL_RST_NUMM 8'hFF
`define FDL_RST_NUML 4'hF
`define FDL_RST_ODIV 8'hF9
`define FDL_MSK_NDHI 8'hFB
`define FDL_MSK_NUMH 8'h3F
`define FDL_B_ALWAYS_ON 7
`define FDL_B_MONITOR 6
`define FDL_B_DURING_CAL 5
`define FDL_B_UNLOCKED 4
`define FDL_B_AUTOCAL 3
`define FDL_B_AUTO_RST 2
`define FDL_B_DITHER 1
`define FDL_B_INT_MODE 0
`define FDL_B_MTCAL 2
`define FDL_B_MUTE 1
`define FDL_B_MODULATOR_RESET_W 5
`define FDL_B_CAL_W 4
`define FDL_B_ST_UNLOCK 5
`define FDL_B_ST_HI 4
`define FDL_B_ST_LO 3
`define FDL_B_ST_LOCK 2
`define FDL_I_PD 0
`define FDL_I_LOCK 1
`define FDL_I_MUTE 2
`define FDL_I_HI 3
`define FDL_I_LO 4
`define FDL_CAL_TICKS 4'hD
`endif

// file: pkg/fdl_pkg.sv
// Types of the divider and level control block
`default_nettype none
package fdl_pkg;
  typedef struct packed {
    logic [7:0] pwr;
    logic [7:0] ctl;
    logic [7:0] seed;
    logic [7:0] ndhi;
    logic [7:0] ndlo;
    logic [7:0] numh;
    logic [7:0] numm;
    logic [3:0] numl;
    logic [7:0] odiv;
  } fdl_regs_t;
  typedef struct packed {
    logic [9:0] feedback_divide_ratio;
    logic fb_upd;
    logic lvl_corr;
    logic lvl_eval;
    logic amplitude_too_high_flag;
    logic amplitude_too_low_flag;
    logic cal_busy;
    logic rf_mute;
    logic div_out;
  } fdl_out_t;
  typedef struct packed {
    fdl_regs_t rg;
    logic [4:0][2:0] sh;
    logic [4:0] lv;
    logic modulator_reset;
    logic cal;
    logic [3:0] cal_cnt;
    logic [17:0] acc;
    logic [7:0] lfsr;
    logic dlast;
    logic [2:0] odcnt;
    logic [7:0] rdata;
    fdl_out_t o;
  } fdl_st_t;
endpackage
`default_nettype wire

// file: rtl/fdl_top.sv
// Fractional feedback divider, output divider, mute and level control
// Contract
// RULE1: Always-on bit runs level control continuously, ignoring the other enables.
// RULE2: During-calibration bit runs level control for every calibration cycle.
// RULE3: When-unlocked bit runs level control while the PLL is out of lock.
// RULE4: Monitor-only bit updates amplitude flags without applying correction.
// RULE5: Amplitude flags are valid only while level control or monitoring runs.
// RULE6: Host keeps at least one of always-on, during-cal or unlocked set.
// RULE7: Ratio is 10 bits; fractional mode uses 35 to 1019 only.
// RULE8: Integer mode accepts ratios 32 to 1023 taken straight from the field.
// RULE9: Ratio upper bits sit in register 6, lower eight bits in register 7.
// RULE10: Modulator steps once per phase-detector cycle; average ratio hits the target.
// RULE11: Numerator is 18 bits, 1 to 262143, denominator fixed at 262144.
// RULE12: Integer mode holds the modulator in standby, resuming at once when cleared.
// RULE13: Dither bit adds pseudorandom dither to the numerator; on after reset.
// RULE14: Dither generator starts from the 8-bit seed field.
// RULE15: Writing one to modulator reset reinitialises it, then the bit self-clears.
// RULE16: With auto-reset set, writes to registers 5 to 0x0A set modulator reset.
// RULE17: Host should reset the modulator after numerator changes unless auto-reset.
// RULE18: Output divider divides by 1 to 6 with 50% duty, odd values too.
// RULE19: Output muted when the mute bit is set or mute pin is low.
// RULE20: Writing one to calibrate starts a cycle; bit clears when it completes.
// RULE21: Correction enable is always-on, or during-cal and busy, or unlocked and no lock.
//
// Decided for this implementation: the register offsets and strobed register access.
`include "fdl_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module fdl_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pins from the analog side
  input wire logic phase_detector_clk,
  input wire logic pll_lock,
  input wire logic mute_n,
  input wire logic amp_above,
  input wire logic amp_below,
  // Controls to the analog side
  output fdl_pkg::fdl_out_t ctl_out
);

  fdl_pkg::fdl_st_t r;
  fdl_pkg::fdl_st_t n;
  logic [4:0] pin_v;

  function automatic logic f_in(input logic [3:0] a, input logic [3:0] lo);
    f_in = (a >= lo) && (a <= `FDL_A_LAST);
  endfunction

  // Taps give a maximal 255-state sequence; an all-zero seed would stall it
  function automatic logic [7:0] f_lfsr(input logic [7:0] s);
    f_lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Out-of-range codes clamp so the counter never runs away
  function automatic logic [2:0] f_odv(input logic [2:0] od);
    if (od == 3'h0) begin
      f_odv = 3'h1;
    end else if (od > 3'h6) begin
      f_odv = 3'h6;
    end else begin
      f_odv = od;
    end
  endfunction

  assign pin_v = {amp_below, amp_above, mute_n, pll_lock, phase_detector_clk};

  always_comb begin
    logic tick;
    logic lock;
    logic req;
    logic eval;
    logic rst_set;
    logic cal_set;
    logic dith;
    logic [9:0] nd;
    logic [17:0] num;
    logic [18:0] sum;
    logic [2:0] odv;
    logic [7:0] st;
    tick = 1'b0;
    lock = 1'b0;
    req = 1'b0;
    eval = 1'b0;
    rst_set = 1'b0;
    cal_set = 1'b0;
    dith = 1'b0;
    nd = {r.rg.ndhi[1:0], r.rg.ndlo}; // [RULE9]
    num = {r.rg.numh[5:0], r.rg.numm, r.rg.numl}; // [RULE11]
    sum = 19'h00000;
    odv = f_odv(r.rg.odiv[2:0]);
    st = 8'h00;
    n = r;
    n.o.fb_upd = 1'b0;
    n.rdata = 8'h00;
    // Pin synchronisers: a change counts once stages two and three agree
    for (int i = 0; i < 5; i++) begin
      n.sh[i] = {r.sh[i][1:0], pin_v[i]};
      if (r.sh[i][1] == r.sh[i][2]) begin
        n.lv[i] = r.sh[i][1];
      end
    end
    tick = r.sh[`FDL_I_PD][1] & r.sh[`FDL_I_PD][2] & ~r.lv[`FDL_I_PD];
    lock = r.lv[`FDL_I_LOCK];
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `FDL_A_PWR: n.rg.pwr = reg_wdata;
        `FDL_A_CTL: n.rg.ctl = reg_wdata;
        `FDL_A_SEED: n.rg.seed = reg_wdata;
        `FDL_A_NDHI: n.rg.ndhi = reg_wdata & `FDL_MSK_NDHI; // [RULE9]
        `FDL_A_NDLO: n.rg.ndlo = reg_wdata; // [RULE9]
        `FDL_A_NUMH: n.rg.numh = reg_wdata & `FDL_MSK_NUMH;
        `FDL_A_NUMM: n.rg.numm = reg_wdata;
        `FDL_A_NUML: begin
          n.rg.numl = reg_wdata[7:4];
          rst_set = reg_wdata[`FDL_B_MODULATOR_RESET_W - 4]; // [RULE15]
          cal_set = reg_wdata[`FDL_B_CAL_W - 4]; // [RULE20]
        end
        `FDL_A_ODIV: n.rg.odiv = reg_wdata;
        default: ;
      endcase
      if (r.rg.ctl[`FDL_B_AUTO_RST] && f_in(reg_addr, `FDL_A_SEED)) begin
        rst_set = 1'b1; // [RULE16]
      end
      if (r.rg.ctl[`FDL_B_AUTOCAL] && f_in(reg_addr, `FDL_A_ACAL_LO)) begin
        cal_set = 1'b1;
      end
    end
    // Register reads: data stands only in the following cycle
    if (reg_rd) begin
      st[`FDL_B_ST_UNLOCK] = ~lock;
      st[`FDL_B_ST_HI] = r.o.amplitude_too_high_flag;
      st[`FDL_B_ST_LO] = r.o.amplitude_too_low_flag;
      st[`FDL_B_ST_LOCK] = lock;
      case (reg_addr)
        `FDL_A_STAT: n.rdata = st;
        `FDL_A_PWR: n.rdata = r.rg.pwr;
        `FDL_A_CTL: n.rdata = r.rg.ctl;
        `FDL_A_SEED: n.rdata = r.rg.seed;
        `FDL_A_NDHI: n.rdata = r.rg.ndhi;
        `FDL_A_NDLO: n.rdata = r.rg.ndlo;
        `FDL_A_NUMH: n.rdata = r.rg.numh;
        `FDL_A_NUMM: n.rdata = r.rg.numm;
        `FDL_A_NUML: n.rdata = {r.rg.numl, 2'h0, r.modulator_reset, r.cal};
        `FDL_A_ODIV: n.rdata = r.rg.odiv;
        default: n.rdata = 8'h00;
      endcase
    end
    // Self-clearing reset pulse; a new request always wins
    n.modulator_reset = rst_set; // [RULE15]
    // Calibration cycle counted in phase-detector periods
    if (cal_set) begin
      n.cal = 1'b1; // [RULE20]
      n.cal_cnt = 4'h0;
    end else if (r.cal && tick) begin
      if (r.cal_cnt == `FDL_CAL_TICKS - 4'h1) begin
        n.cal = 1'b0; // [RULE20]
      end else begin
        n.cal_cnt = r.cal_cnt + 4'h1;
      end
    end
    // Modulator: first-difference dither keeps the average numerator exact
    if (r.modulator_reset) begin
      n.acc = 18'h00000; // [RULE15]
      n.lfsr = r.rg.seed; // [RULE14]
      n.dlast = 1'b0;
    end else if (tick) begin
      n.o.fb_upd = 1'b1; // [RULE10]
      if (r.rg.ctl[`FDL_B_INT_MODE]) begin
        n.o.feedback_divide_ratio = nd; // [RULE8] [RULE12]
      end else begin
        dith = r.rg.ctl[`FDL_B_DITHER] & r.lfsr[0]; // [RULE13]
        sum = {1'b0, r.acc} + {1'b0, num} + {18'h00000, dith} - {18'h00000, r.dlast}; // [RULE11]
        n.acc = sum[17:0];
        n.o.feedback_divide_ratio = nd + {9'h000, sum[18]}; // [RULE7] [RULE10]
        n.lfsr = f_lfsr(r.lfsr);
        n.dlast = dith;
      end
    end
    // Level control decision
    req = (r.rg.ctl[`FDL_B_DURING_CAL] & r.cal) | (r.rg.ctl[`FDL_B_UNLOCKED] & ~lock); // [RULE2] [RULE3]
    n.o.lvl_corr = r.rg.ctl[`FDL_B_ALWAYS_ON] | (req & ~r.rg.ctl[`FDL_B_MONITOR]); // [RULE1] [RULE4] [RULE21]
    eval = r.rg.ctl[`FDL_B_ALWAYS_ON] | req | r.rg.ctl[`FDL_B_MONITOR];
    n.o.lvl_eval = eval; // [RULE4]
    // Flags hold outside evaluation; they are meaningless there anyway
    if (eval) begin
      n.o.amplitude_too_high_flag = r.lv[`FDL_I_HI]; // [RULE5]
      n.o.amplitude_too_low_flag = r.lv[`FDL_I_LO]; // [RULE5]
    end
    n.o.cal_busy = n.cal;
    n.o.rf_mute = r.rg.pwr[`FDL_B_MUTE] | ~r.lv[`FDL_I_MUTE] | (r.rg.pwr[`FDL_B_MTCAL] & r.cal); // [RULE19]
    // Clock is taken as twice the source rate, so a toggle every O cycles gives 50% duty
    if (r.odcnt >= odv - 3'h1) begin
      n.odcnt = 3'h0;
      n.o.div_out = ~r.o.div_out; // [RULE18]
    end else begin
      n.odcnt = r.odcnt + 3'h1;
    end
    if (srst) begin
      n = '0;
      n.rg.pwr = `FDL_RST_PWR;
      n.rg.ctl = `FDL_RST_CTL; // [RULE13]
      n.rg.seed = `FDL_RST_SEED;
      n.rg.ndhi = `FDL_RST_NDHI;
      n.rg.ndlo = `FDL_RST_NDLO;
      n.rg.numh = `FDL_RST_NUMH;
      n.rg.numm = `FDL_RST_NUMM;
      n.rg.numl = `FDL_RST_NUML;
      n.rg.odiv = `FDL_RST_ODIV;
      n.lfsr = `FDL_RST_SEED;
      n.o.rf_mute = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign reg_rdata = r.rdata;
  assign ctl_out = r.o;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_always_on;
    r.rg.ctl[`FDL_B_ALWAYS_ON] |=> ctl_out.lvl_corr && ctl_out.lvl_eval;
  endproperty
  a_always_on: assert property (p_always_on) else $error("always-on did not enable correction"); // [RULE1]

  property p_during_cal;
    r.cal && r.rg.ctl[`FDL_B_DURING_CAL] && !r.rg.ctl[`FDL_B_MONITOR] |=> ctl_out.lvl_corr;
  endproperty
  a_during_cal: assert property (p_during_cal) else $error("no correction during calibration"); // [RULE2]

  property p_unlocked;
    !r.lv[`FDL_I_LOCK] && r.rg.ctl[`FDL_B_UNLOCKED] && !r.rg.ctl[`FDL_B_MONITOR] |=> ctl_out.lvl_corr;
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("no correction while unlocked"); // [RULE3]

  property p_monitor;
    r.rg.ctl[`FDL_B_MONITOR] && !r.rg.ctl[`FDL_B_ALWAYS_ON] |=> ctl_out.lvl_eval && !ctl_out.lvl_corr;
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor mode applied correction"); // [RULE4]

  property p_flags;
    r.rg.ctl[`FDL_B_MONITOR] |=> ctl_out.amplitude_too_high_flag == $past(r.lv[`FDL_I_HI]);
  endproperty
  a_flags: assert property (p_flags) else $error("high flag not tracking amplitude"); // [RULE5]

  logic tick_seen;
  assign tick_seen = r.sh[`FDL_I_PD][1] && r.sh[`FDL_I_PD][2] && !r.lv[`FDL_I_PD] && !r.modulator_reset;
  property p_ratio;
    tick_seen |=> ctl_out.fb_upd;
  endproperty
  a_ratio: assert property (p_ratio) else $error("divider not updated on phase-detector edge"); // [RULE10]

  property p_int_hold;
    r.rg.ctl[`FDL_B_INT_MODE] && !r.modulator_reset |=> $stable(r.acc);
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("modulator moved in integer mode"); // [RULE12]

  property p_mod_rst;
    reg_wr && reg_addr == `FDL_A_NUML && reg_wdata[`FDL_B_MODULATOR_RESET_W - 4] |=> r.modulator_reset ##1
      (r.acc == 18'h00000 && r.lfsr == $past(r.rg.seed));
  endproperty
  a_mod_rst: assert property (p_mod_rst) else $error("modulator not reinitialised"); // [RULE15]

  property p_auto_rst;
    reg_wr && reg_addr >= `FDL_A_SEED && reg_addr <= `FDL_A_LAST && r.rg.ctl[`FDL_B_AUTO_RST] |=> r.modulator_reset;
  endproperty
  a_auto_rst: assert property (p_auto_rst) else $error("auto reset missing"); // [RULE16]

  property p_cal_end;
    r.cal |-> r.cal_cnt < `FDL_CAL_TICKS;
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("calibration overran"); // [RULE20]

  property p_mute;
    !r.lv[`FDL_I_MUTE] |=> ctl_out.rf_mute;
  endproperty
  a_mute: assert property (p_mute) else $error("mute pin ignored"); // [RULE19]

  property p_odiv;
    $changed(ctl_out.div_out) |-> r.odcnt == 3'h0;
  endproperty
  a_odiv: assert property (p_odiv) else $error("output divider half period wrong"); // [RULE18]

  c_cal_done: cover property (r.cal ##1 !r.cal);
  c_carry: cover property (ctl_out.fb_upd && ctl_out.feedback_divide_ratio != {r.rg.ndhi[1:0], r.rg.ndlo});
  c_auto_rst: cover property (reg_wr && r.rg.ctl[`FDL_B_AUTO_RST] ##1 r.modulator_reset);
endmodule
`default_nettype wire

// file: test/fdl_ana_model.sv
// Analog-side model: phase-detector clock source
`timescale 1ns/1ps
`default_nettype none
module fdl_ana_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Phase-detector clock pin
  output logic pd_clk
);
  // Runs free like the reference; a 16 clk period leaves room for writes between steps
  logic [3:0] cnt_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  assign pd_clk = cnt_ff[3];
endmodule
`default_nettype wire

// file: test/fdl_top_test.sv
// Self-checking bench of the divider and level control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module fdl_top_test;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [7:0] reg_rdata;
  logic pd_clk;
  logic pll_lock = 1'h1;
  logic mute_n = 1'h1;
  logic amp_above = 1'h0;
  logic amp_below = 1'h0;
  fdl_pkg::fdl_out_t ctl_out;
  int failures = 0;
  int cmp_count = 0;
  logic [15:0] s;
  logic [3:0] ra [11] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hE};
  logic [7:0] rv [11] = '{8'h00, 8'h06, 8'h3E, 8'h11, 8'h08, 8'hFA, 8'h3F, 8'hFF, 8'hF0, 8'hF9, 8'h00};
  always #50 clk = ~clk;
  fdl_ana_model ana_u (.clk(clk), .srst(srst), .pd_clk(pd_clk));
  fdl_top dut_u (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_detector_clk(pd_clk), .pll_lock(pll_lock),
    .mute_n(mute_n), .amp_above(amp_above), .amp_below(amp_below), .ctl_out(ctl_out));
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // Pins pass a synchroniser, so give them eight cycles
  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  // Sum of the ratios of the next n modulator steps
  task automatic steps(input int n);
    s = 16'h0000;
    repeat (n) begin
      for (int k = 0; k < 40; k++) begin
        tick;
        if (ctl_out.fb_upd === 1'h1) break;
      end
      s = s + 16'(ctl_out.feedback_divide_ratio);
    end
  endtask
  task automatic odiv(input logic [2:0] o);
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    wr(4'hB, {5'h1F, o});
    repeat (20) tick;
    for (int k = 0; k < 20 && ctl_out.div_out !== 1'h0; k++) tick;
    for (int k = 0; k < 20 && ctl_out.div_out !== 1'h1; k++) tick;
    while (ctl_out.div_out === 1'h1 && hi < 20) begin
      tick;
      hi++;
    end
    while (ctl_out.div_out === 1'h0 && lo < 20) begin
      tick;
      lo++;
    end
    `CHK("div_high", int'(o), hi)
    `CHK("div_low", int'(o), lo)
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    tick;
    `CHK("rf_mute", 1'h1, ctl_out.rf_mute)
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(4'h2, 8'h00);
    settle;
    `CHK("rf_mute", 1'h0, ctl_out.rf_mute)
    @(posedge clk) mute_n <= 1'h0;
    settle;
    `CHK("rf_mute", 1'h1, ctl_out.rf_mute)
    @(posedge clk) mute_n <= 1'h1;
    wr(4'h3, 8'hD0);
    settle;
    `CHK("lvl_corr", 1'h1, ctl_out.lvl_corr)
    wr(4'h3, 8'h10);
    settle;
    `CHK("lvl_corr", 1'h0, ctl_out.lvl_corr)
    `CHK("lvl_eval", 1'h0, ctl_out.lvl_eval)
    @(posedge clk) pll_lock <= 1'h0;
    settle;
    `CHK("lvl_corr", 1'h1, ctl_out.lvl_corr)
    rd(4'h0, 8'h20);
    @(posedge clk) pll_lock <= 1'h1;
    @(posedge clk) amp_above <= 1'h1;
    @(posedge clk) amp_below <= 1'h1;
    wr(4'h3, 8'h60);
    settle;
    `CHK("lvl_corr", 1'h0, ctl_out.lvl_corr)
    `CHK("flag_high", 1'h1, ctl_out.amplitude_too_high_flag)
    `CHK("flag_low", 1'h1, ctl_out.amplitude_too_low_flag)
    rd(4'h0, 8'h1C);
    @(posedge clk) amp_above <= 1'h0;
    @(posedge clk) amp_below <= 1'h0;
    wr(4'h3, 8'h20);
    wr(4'hA, 8'h01);
    settle;
    `CHK("lvl_corr", 1'h1, ctl_out.lvl_corr)
    `CHK("cal_busy", 1'h1, ctl_out.cal_busy)
    for (int k = 0; k < 400 && ctl_out.cal_busy === 1'h1; k++) tick;
    settle;
    `CHK("cal_busy", 1'h0, ctl_out.cal_busy)
    `CHK("lvl_corr", 1'h0, ctl_out.lvl_corr)
    rd(4'hA, 8'h00);
    // Quarter numerator: exactly one carry in any four steps
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h64);
    wr(4'h8, 8'h10);
    wr(4'h9, 8'h00);
    steps(1);
    wr(4'hA, 8'h02);
    steps(4);
    `CHK("ratio_sum", 16'h0191, s)
    steps(3);
    wr(4'hA, 8'h02);
    steps(2);
    `CHK("ratio_sum", 16'h00C8, s)
    steps(1);
    wr(4'h3, 8'h24);
    wr(4'h5, 8'h11);
    steps(2);
    `CHK("ratio_sum", 16'h00C8, s)
    wr(4'h3, 8'h21);
    wr(4'h6, 8'h03);
    wr(4'h7, 8'hFF);
    steps(1);
    steps(2);
    `CHK("ratio_sum", 16'h07FE, s)
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h20);
    steps(1);
    steps(2);
    `CHK("ratio_sum", 16'h0040, s)
    wr(4'h7, 8'h64);
    wr(4'h3, 8'h20);
    steps(1);
    steps(4);
    `CHK("ratio_sum", 16'h0191, s)
    for (int o = 1; o <= 6; o++) odiv(3'(o));
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out;
  end
endmodule
`default_nettype wire
